//--- shared/tpc_pkg.sv
// constants for the tach phase comparator logic
package tpc_pkg;
  // clock and oscillator timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned OSC_FREQ_KHZ = 256;
  localparam int unsigned OSC_PERIOD_NS = 1000000 / OSC_FREQ_KHZ;
  localparam int unsigned OSC_HALF_CYC = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned DIV_RATIO = 4;
  // one-shot widths
  localparam int unsigned EDGE_PULSE_NS = 440;
  localparam int unsigned EDGE_PULSE_CYC = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DET_PULSE_NS = 1000;
  localparam int unsigned DET_PULSE_CYC = (DET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_NS = 2000;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // activity timeout
  localparam int unsigned FAIL_US = 100;
  localparam int unsigned FAIL_CYC = (FAIL_US * 1000) / CLK_PERIOD_NS;
  // register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hc;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic SWITCH_RESET = 1'b1;
  // irq bit positions
  localparam int unsigned IRQ_REF_FAIL = 0;
  localparam int unsigned IRQ_PHASE_FAIL = 1;
  localparam int unsigned IRQ_SWITCH = 2;
endpackage

//--- logic/tpc_logic.sv
// tach phase comparator: timing generator, comparator, channel switch
module tpc_oneshot #(
  parameter int unsigned WIDTH_CYC = 1,
  parameter bit RETRIG = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // trigger and pulse
  input wire logic trig,
  output logic pulse
);
  logic [15:0] cnt;

  // pulse of fixed width, restarted by trigger when retriggerable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= 16'h0;
      pulse <= 1'b0;
    end else if (trig && (RETRIG || !pulse)) begin
      cnt <= 16'(WIDTH_CYC);
      pulse <= 1'b1;
    end else if (cnt == 16'h1) begin
      cnt <= 16'h0;
      pulse <= 1'b0;
    end else if (cnt != 16'h0) begin
      cnt <= cnt - 16'h1;
    end
  end
endmodule

module tpc_logic #(
  parameter int unsigned FAIL_TIMEOUT_CYC = tpc_pkg::FAIL_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // timing generator
  input wire logic bandpass_square,
  output logic sample_phase_a,
  output logic sample_phase_b,
  output logic reference_out_p,
  output logic reference_out_n,
  output logic phase_variable_signal_p,
  output logic phase_variable_signal_n,
  // comparator inputs
  input wire logic reference_in,
  input wire logic phase_variable_signal_in,
  // comparator outputs
  output logic channel_a_duty_position,
  output logic channel_b_duty_position,
  output logic channel_a_switch_drive,
  output logic channel_b_switch_drive,
  output logic channel_a_select_indicator,
  output logic channel_b_select_indicator,
  output logic channel_a_blank_drive,
  output logic channel_b_blank_drive,
  output logic phase_signal_fail_flag,
  output logic reference_fail_flag
);
  localparam int OSC_GAP = tpc_pkg::OSC_HALF_CYC;
  localparam logic [7:0] OSC_LAST = 8'(tpc_pkg::OSC_HALF_CYC - 1);
  localparam logic [1:0] DIV_LAST = 2'(tpc_pkg::DIV_RATIO - 1);
  localparam logic [15:0] FAIL_LAST = 16'(FAIL_TIMEOUT_CYC - 1);

  logic [7:0] osc_cnt;
  logic osc, halved, osc_tog;
  logic next_osc, next_halved;
  logic [1:0] ref_div, pvs_div;
  logic [2:0] sync1, sync2, sync3;
  logic ref_rise, ref_edge, pvs_rise, pvs_fall, pvs_edge, bp_rise;
  logic os_a, os_b, os_c;
  logic det0_raw, det180_raw, det0, det180;
  logic switch_a, detect_en;
  logic [15:0] ref_idle, pvs_idle;
  logic [2:0] irq_stat, irq_mask, irq_ev;
  logic stat_rd;

  // oscillator from the system clock
  assign osc_tog = (osc_cnt == OSC_LAST);
  assign next_osc = osc ^ osc_tog;
  assign next_halved = halved ^ (osc_tog & !osc);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      osc_cnt <= 8'h0;
      osc <= 1'b0;
      halved <= 1'b0;
    end else begin
      osc_cnt <= osc_tog ? 8'h0 : osc_cnt + 8'h1;
      osc <= next_osc;
      halved <= next_halved;
    end
  end

  // quadrature sampling phases
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sample_phase_a <= 1'b1;
      sample_phase_b <= 1'b0;
    end else begin
      sample_phase_a <= next_osc ^ 1'b1;
      sample_phase_b <= next_osc ^ next_halved;
    end
  end

  // reference divider on rising phase a
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_div <= 2'h0;
      reference_out_p <= 1'b0;
      reference_out_n <= 1'b1;
    end else if (osc_tog && osc) begin
      ref_div <= (ref_div == DIV_LAST) ? 2'h0 : ref_div + 2'h1;
      reference_out_p <= (ref_div == DIV_LAST) || (ref_div == 2'h0);
      reference_out_n <= !((ref_div == DIV_LAST) || (ref_div == 2'h0));
    end
  end

  // pin synchronisers and edge history, left running through reset so no false edge follows it
  always_ff @(posedge ref_clk) begin
    sync1 <= {bandpass_square, phase_variable_signal_in, reference_in};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  assign ref_rise = sync2[0] && !sync3[0];
  assign ref_edge = sync2[0] ^ sync3[0];
  assign pvs_rise = sync2[1] && !sync3[1];
  assign pvs_fall = !sync2[1] && sync3[1];
  assign pvs_edge = sync2[1] ^ sync3[1];
  assign bp_rise = sync2[2] && !sync3[2];

  // divide squared bandpass by four
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pvs_div <= 2'h0;
      phase_variable_signal_p <= 1'b0;
      phase_variable_signal_n <= 1'b1;
    end else if (bp_rise) begin
      pvs_div <= (pvs_div == DIV_LAST) ? 2'h0 : pvs_div + 2'h1;
      phase_variable_signal_p <= (pvs_div == DIV_LAST) || (pvs_div == 2'h0);
      phase_variable_signal_n <= !((pvs_div == DIV_LAST) || (pvs_div == 2'h0));
    end
  end

  // edge one-shots a, b and c
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::EDGE_PULSE_CYC), .RETRIG(1'b0)) u_os_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(ref_rise),
    .pulse(os_a)
  );
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::EDGE_PULSE_CYC), .RETRIG(1'b0)) u_os_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(pvs_fall),
    .pulse(os_b)
  );
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::EDGE_PULSE_CYC), .RETRIG(1'b0)) u_os_c (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(pvs_rise),
    .pulse(os_c)
  );

  // duty-coded position flip-flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      channel_a_duty_position <= 1'b0;
      channel_b_duty_position <= 1'b0;
    end else begin
      if (ref_rise) begin
        channel_a_duty_position <= 1'b1;
      end else if (pvs_rise) begin
        channel_a_duty_position <= 1'b0;
      end
      if (ref_rise) begin
        channel_b_duty_position <= 1'b1;
      end else if (pvs_fall) begin
        channel_b_duty_position <= 1'b0;
      end
    end
  end

  // coincidence bands set by one-shot overlap
  assign det0_raw = os_a && os_c;
  assign det180_raw = os_a && os_b;

  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::DET_PULSE_CYC), .RETRIG(1'b0)) u_det0 (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(det0_raw),
    .pulse(det0)
  );
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::DET_PULSE_CYC), .RETRIG(1'b0)) u_det180 (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(det180_raw),
    .pulse(det180)
  );

  // channel switch: 180 sets (use a), 0 resets (use b)
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      switch_a <= tpc_pkg::SWITCH_RESET;
    end else if (detect_en && det180 && !det0) begin
      switch_a <= 1'b1;
    end else if (detect_en && det0 && !det180) begin
      switch_a <= 1'b0;
    end
  end

  // switch drives and indicators
  assign channel_a_switch_drive = switch_a;
  assign channel_b_switch_drive = !switch_a;
  assign channel_a_select_indicator = switch_a;
  assign channel_b_select_indicator = !switch_a;

  // retrace blanking per channel
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::BLANK_CYC), .RETRIG(1'b1)) u_blank_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(det0_raw),
    .pulse(channel_a_blank_drive)
  );
  tpc_oneshot #(.WIDTH_CYC(tpc_pkg::BLANK_CYC), .RETRIG(1'b1)) u_blank_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .trig(det180_raw),
    .pulse(channel_b_blank_drive)
  );

  // activity monitors
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_idle <= 16'h0;
      reference_fail_flag <= 1'b0;
    end else if (ref_edge) begin
      ref_idle <= 16'h0;
      reference_fail_flag <= 1'b0;
    end else if (ref_idle == FAIL_LAST) begin
      reference_fail_flag <= 1'b1;
    end else begin
      ref_idle <= ref_idle + 16'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pvs_idle <= 16'h0;
      phase_signal_fail_flag <= 1'b0;
    end else if (pvs_edge) begin
      pvs_idle <= 16'h0;
      phase_signal_fail_flag <= 1'b0;
    end else if (pvs_idle == FAIL_LAST) begin
      phase_signal_fail_flag <= 1'b1;
    end else begin
      pvs_idle <= pvs_idle + 16'h1;
    end
  end

  // control and mask writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      detect_en <= tpc_pkg::CTRL_RESET;
      irq_mask <= tpc_pkg::IRQ_MASK_RESET;
    end else if (reg_wr && reg_addr == tpc_pkg::CTRL_OFS) begin
      detect_en <= reg_wdata[0];
    end else if (reg_wr && reg_addr == tpc_pkg::IRQ_MASK_OFS) begin
      irq_mask <= reg_wdata[2:0];
    end
  end

  // sticky events, cleared by read, set wins
  assign irq_ev[tpc_pkg::IRQ_REF_FAIL] = (ref_idle == FAIL_LAST) && !ref_edge && !reference_fail_flag;
  assign irq_ev[tpc_pkg::IRQ_PHASE_FAIL] = (pvs_idle == FAIL_LAST) && !pvs_edge && !phase_signal_fail_flag;
  assign irq_ev[tpc_pkg::IRQ_SWITCH] = detect_en && (det0 ^ det180) && (switch_a != det180);
  assign stat_rd = reg_rd && reg_addr == tpc_pkg::IRQ_STATUS_OFS;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (stat_rd ? 3'h0 : irq_stat) | irq_ev;
      irq <= |(((stat_rd ? 3'h0 : irq_stat) | irq_ev) & irq_mask);
    end
  end

  // read data, one cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 32'h0;
    end else if (reg_addr == tpc_pkg::CTRL_OFS) begin
      reg_rdata <= {31'h0, detect_en};
    end else if (reg_addr == tpc_pkg::STATUS_OFS) begin
      reg_rdata <= {25'h0, channel_b_blank_drive, channel_a_blank_drive,
                    channel_b_duty_position, channel_a_duty_position,
                    phase_signal_fail_flag, reference_fail_flag, switch_a};
    end else if (reg_addr == tpc_pkg::IRQ_STATUS_OFS) begin
      reg_rdata <= {29'h0, irq_stat};
    end else if (reg_addr == tpc_pkg::IRQ_MASK_OFS) begin
      reg_rdata <= {29'h0, irq_mask};
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  chk_phase_quad: assert property (
    sample_phase_b == (!sample_phase_a ^ halved))
    else $error("phase b not quadrature of phase a");
  chk_osc_period: assert property (
    $changed(osc) |-> ##OSC_GAP $changed(osc))
    else $error("oscillator half period wrong");
  chk_ref_divide: assert property (
    $changed(ref_div) |-> $fell(osc) && (reference_out_n != reference_out_p))
    else $error("reference divider stepped off phase a rise");
  chk_pvs_divide: assert property (
    $changed(pvs_div) |-> $past(bp_rise))
    else $error("phase divider stepped without input rise");
  chk_pulse_edges: assert property (
    $rose(os_b) |-> $past(pvs_fall) ##1 os_b[*8])
    else $error("pulse b not from falling phase edge");
  chk_duty_reset: assert property (
    pvs_rise && !ref_rise |=> !channel_a_duty_position && $stable(channel_b_duty_position))
    else $error("channel a duty not reset by pulse c");
  chk_duty_set: assert property (
    ref_rise |=> channel_a_duty_position && channel_b_duty_position)
    else $error("duty flip-flops not set by pulse a");
  chk_det_band: assert property (
    $rose(det0) |-> $past(os_a && os_c))
    else $error("zero detector fired without coincidence");
  chk_switch_set: assert property (
    detect_en && det180 && !det0 |=> switch_a && channel_a_switch_drive)
    else $error("180 detector did not select channel a");
  chk_switch_outs: assert property (
    (channel_a_switch_drive != channel_b_switch_drive)
    && (channel_a_select_indicator == channel_a_switch_drive))
    else $error("switch drives not complementary");
  chk_blank_hold: assert property (
    det180_raw |=> channel_b_blank_drive[*8])
    else $error("channel b blanking too short");
  chk_fail_clear: assert property (
    ref_edge |=> !reference_fail_flag)
    else $error("reference fail flag stuck after edge");

  cov_switch_to_a: cover property ($rose(switch_a));
  cov_switch_to_b: cover property ($fell(switch_a));
  cov_ref_fail: cover property ($rose(reference_fail_flag));
  cov_irq: cover property ($rose(irq));
endmodule

//--- verif/tpc_enc_model.sv
// encoder sampling chain model: reference, phase variable and bandpass squares
module tpc_enc_model (
  // clock
  input wire logic ref_clk,
  // control from the bench
  input wire logic run,
  input wire logic [15:0] half_cyc,
  input wire logic [15:0] lag_cyc,
  input wire logic [15:0] bp_half,
  // pins toward the block
  output logic reference_in,
  output logic phase_variable_signal_in,
  output logic bandpass_square
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int bcnt = 0;
  int per;
  // squares advance only while running, a stopped chain holds its levels
  always @(posedge ref_clk) begin
    if (run) begin
      cnt <= (cnt + 1) % per;
      bcnt <= (bcnt + 1) % (2 * int'(bp_half));
    end
  end
  // phase variable lags the reference by lag_cyc
  assign per = 2 * int'(half_cyc);
  assign reference_in = cnt < int'(half_cyc);
  assign phase_variable_signal_in = ((cnt + per - int'(lag_cyc)) % per) < int'(half_cyc);
  assign bandpass_square = bcnt < int'(bp_half);
endmodule

//--- verif/tb.sv
// self-checking bench for the tach phase comparator logic
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, reg_wr, reg_rd, run, irq;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] half_cyc, lag_cyc, bp_half;
  logic ref_pin, pvs_pin, bp_pin, sp_a, sp_b, ro_p, ro_n, pv_p, pv_n;
  logic dp_a, dp_b, sw_a, sw_b, in_a, in_b, bl_a, bl_b, pf, rf;
  logic [9:0] mon;
  int num_errors = 0;
  int num_checks = 0;
  int unsigned seed = 95;
  int w, lag;

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  tpc_logic #(.FAIL_TIMEOUT_CYC(600)) dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .bandpass_square(bp_pin), .sample_phase_a(sp_a), .sample_phase_b(sp_b), .reference_out_p(ro_p),
    .reference_out_n(ro_n), .phase_variable_signal_p(pv_p), .phase_variable_signal_n(pv_n),
    .reference_in(ref_pin), .phase_variable_signal_in(pvs_pin), .channel_a_duty_position(dp_a),
    .channel_b_duty_position(dp_b), .channel_a_switch_drive(sw_a), .channel_b_switch_drive(sw_b),
    .channel_a_select_indicator(in_a), .channel_b_select_indicator(in_b),
    .channel_a_blank_drive(bl_a), .channel_b_blank_drive(bl_b),
    .phase_signal_fail_flag(pf), .reference_fail_flag(rf));

  tpc_enc_model enc (.ref_clk(ref_clk), .run(run), .half_cyc(half_cyc), .lag_cyc(lag_cyc),
    .bp_half(bp_half), .reference_in(ref_pin), .phase_variable_signal_in(pvs_pin),
    .bandpass_square(bp_pin));

  // watched levels for run-length measurement
  assign mon = {pf, rf, pv_p, ro_p, sp_b, sp_a, bl_b, bl_a, dp_b, dp_a};

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // length of the next high run of mon[i], bounded
  task automatic hi_run(input int i, output int w);
    int n;
    n = 0;
    w = 0;
    while (mon[i] !== 1'b0 && n < 9000) begin
      tick(1);
      n++;
    end
    while (mon[i] !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    while (mon[i] === 1'b1 && n < 9000) begin
      tick(1);
      n++;
      w++;
    end
    if (n >= 9000) begin
      num_errors++;
      $display("MISMATCH wait on level %0d expected edge seen none", i);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what,
    input logic [31:0] msk = 32'hffffffff);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata & msk);
  endtask

  // switch outputs against the expected selected channel
  task automatic chk_switch(input logic a_sel);
    chk("switch drives", {a_sel, ~a_sel}, {sw_a, sw_b});
    chk("indicators", {a_sel, ~a_sel}, {in_a, in_b});
  endtask

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    run = 1'b1;
    half_cyc = 16'h00c8;
    lag_cyc = 16'h0064;
    bp_half = 16'h001e;
    // reset values seen while reset is held
    tick(4);
    chk("reset outputs", 32'h12d00, {sp_a, sp_b, ro_p, ro_n, pv_p, pv_n, sw_a, sw_b, in_a, in_b,
      bl_a, bl_b, pf, rf, dp_a, dp_b, irq});
    @(posedge ref_clk);
    srst <= 1'b0;
    rd(tpc_pkg::CTRL_OFS, 32'h1, "ctrl reset");
    rd(tpc_pkg::IRQ_MASK_OFS, 32'h0, "mask reset");
    rd(4'h2, 32'h0, "unmapped read");
    $display("test reset and registers done");
    // timing generator rates
    hi_run(4, w);
    chk("phase a half period", 244, w);
    hi_run(5, w);
    chk("phase b half period", 488, w);
    hi_run(6, w);
    chk("reference half period", 976, w);
    chk("reference pair", {1'b0, 1'b1}, {ro_p, ro_n});
    hi_run(7, w);
    chk("phase variable half period", 4 * 30, w);
    chk("phase variable pair", {1'b0, 1'b1}, {pv_p, pv_n});
    $display("test timing generator done");
    // duty coded position for random lags away from coincidence
    repeat (2) begin
      lag = 60 + int'(xs() % 81);
      @(posedge ref_clk);
      lag_cyc <= 16'(lag);
      tick(1200);
      hi_run(0, w);
      chk("duty a width", lag, w);
      hi_run(1, w);
      chk("duty b width", lag + 200, w);
    end
    chk_switch(1'b1);
    $display("test duty position done");
    // zero degree coincidence moves to channel b, unmasked event
    wr(tpc_pkg::IRQ_MASK_OFS, 32'h4);
    @(posedge ref_clk);
    lag_cyc <= 16'h000a;
    tick(1200);
    chk_switch(1'b0);
    chk("irq raised", 1, irq);
    hi_run(2, w);
    // retriggered through the whole a/c overlap, which starts 10 cycles into pulse a
    chk("blank a width", tpc_pkg::BLANK_CYC + tpc_pkg::EDGE_PULSE_CYC - 11, w);
    rd(tpc_pkg::IRQ_STATUS_OFS, 32'h4, "switch event");
    tick(2);
    chk("irq cleared", 0, irq);
    $display("test channel b select done");
    // 180 degree coincidence back to channel a, event masked
    wr(tpc_pkg::IRQ_MASK_OFS, 32'h0);
    @(posedge ref_clk);
    lag_cyc <= 16'h00be;
    tick(1200);
    chk_switch(1'b1);
    chk("irq masked", 0, irq);
    hi_run(3, w);
    // pulse b leads the next pulse a by 10 cycles, same overlap as above
    chk("blank b width", tpc_pkg::BLANK_CYC + tpc_pkg::EDGE_PULSE_CYC - 11, w);
    rd(tpc_pkg::IRQ_STATUS_OFS, 32'h4, "masked switch event");
    $display("test channel a select done");
    // inputs stop toggling: fail flags after the timeout
    chk("flags running", 2'b00, {rf, pf});
    wr(tpc_pkg::IRQ_MASK_OFS, 32'h3);
    @(posedge ref_clk);
    run <= 1'b0;
    tick(380);
    chk("flags early", 2'b00, {rf, pf});
    tick(320);
    chk("flags set", 2'b11, {rf, pf});
    chk("irq fail", 1, irq);
    rd(tpc_pkg::STATUS_OFS, 32'h7, "status fail", 32'h67);
    rd(tpc_pkg::IRQ_STATUS_OFS, 32'h3, "fail events");
    tick(2);
    chk("irq after read", 0, irq);
    @(posedge ref_clk);
    run <= 1'b1;
    tick(600);
    chk("flags recover", 2'b00, {rf, pf});
    $display("test input fail done");
    // detection disabled: a zero degree coincidence must not move the switch
    wr(tpc_pkg::CTRL_OFS, 32'h0);
    @(posedge ref_clk);
    lag_cyc <= 16'h000a;
    tick(1200);
    chk_switch(1'b1);
    rd(tpc_pkg::CTRL_OFS, 32'h0, "ctrl disabled");
    wr(tpc_pkg::CTRL_OFS, 32'h1);
    tick(1200);
    chk_switch(1'b0);
    rd(tpc_pkg::IRQ_STATUS_OFS, 32'h4, "enabled switch event");
    $display("test detect enable done");
    tally_and_finish();
  end
endmodule
